// *** rtl/ecf_frame_port.sv ***
// How it works
// - one global register field names the front port of the external processor, used for its traffic.
// - one global mask selects which extraction queues go to the external processor.
// - a per-port egress enable makes the block insert the extraction header into frames leaving that port.
// - a per-port ingress enable makes the block parse an injection header at the start of incoming frames.
// - the external processor may sit on any front port and uses its ordinary byte stream.
// - the side-band header stands before the destination address on both directions.
// - an injected frame goes to the analyzer or straight to the header's destination set, as the header says.
// - queues outside the mask stay with the internal processor.
// - a frame queued for several reasons may be copied to both processors.
// - the extraction header is twenty bytes of classification and reason data.
// - there are eight extraction queues.
// - injected frames are seen inside the core as arriving on port 11.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module ecf_frame_port import ecf_pkg::*; #(
	parameter int NQ = NUM_QUEUES
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// axi4-lite slave
	input  wire logic [3:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [3:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// extraction request from the queue system
	input  wire logic                 xtrReq,
	input  wire logic [NQ-1:0]        xtrQueues,
	output ecf_xtr_t                  xtrOut,
	// egress bytes from core, header side-band, bytes to port
	input  wire ecf_byte_t            egIn,
	input  wire logic [HDR_BYTES*8-1:0] egHeader,
	output logic                      egReady,
	output ecf_byte_t                 txOut,
	// ingress bytes from port, bytes and meta to core
	input  wire ecf_byte_t            rxIn,
	output ecf_byte_t                 coreOut,
	output ecf_meta_t                 coreMeta
);

	logic [PORT_W-1:0]    extPort;
	logic [NQ-1:0]        extMask;
	logic [NUM_PORTS-1:0] insEn;
	logic [NUM_PORTS-1:0] detEn;
	logic [7:0]           injCount;
	logic [7:0]           xtrCount;
	logic                 awHave;
	logic                 wHave;
	logic [3:0]           awAddr;
	logic [31:0]          wData;
	logic [3:0]           wStrb;
	logic                 wrFire;
	logic [31:0]          cfgWord;
	logic [31:0]          modeWord;
	logic [31:0]          next_word;

	assign cfgWord  = {16'h0000, extMask, 4'h0, extPort};
	assign modeWord = {4'h0, detEn, 4'h0, insEn};
	assign wrFire   = awHave && wHave && !s_axi_bvalid;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	assign next_word = merge((awAddr == OFS_EXT_CFG) ? cfgWord : modeWord, wData, wStrb);

	// write channel
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			awHave        <= 1'b0;
			wHave         <= 1'b0;
			awAddr        <= 4'h0;
			wData         <= 32'h0000_0000;
			wStrb         <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr        <= s_axi_awaddr;
				awHave        <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData        <= s_axi_wdata;
				wStrb        <= s_axi_wstrb;
				wHave        <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wrFire) begin
				awHave       <= 1'b0;
				wHave        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awAddr == OFS_EXT_CFG || awAddr == OFS_PORT_MODE || awAddr == OFS_STATUS) ?
					RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// configuration registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			extPort <= RST_EXT_PORT;
			extMask <= RST_EXT_MASK;
			insEn   <= RST_PORT_EN;
			detEn   <= RST_PORT_EN;
		end else if (wrFire && awAddr == OFS_EXT_CFG) begin
			extPort <= next_word[EXT_PORT_LSB +: PORT_W];
			extMask <= next_word[EXT_MASK_LSB +: NQ];
		end else if (wrFire && awAddr == OFS_PORT_MODE) begin
			insEn <= next_word[INS_EN_LSB +: NUM_PORTS];
			detEn <= next_word[DET_EN_LSB +: NUM_PORTS];
		end
	end

	// read channel
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			unique case (s_axi_araddr)
				OFS_EXT_CFG:   s_axi_rdata <= cfgWord;
				OFS_PORT_MODE: s_axi_rdata <= modeWord;
				OFS_STATUS:    s_axi_rdata <= {16'h0000, xtrCount, injCount};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// extraction queue routing
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			xtrOut   <= '0;
			xtrCount <= 8'h00;
		end else begin
			xtrOut.extQueues <= xtrQueues & extMask;
			xtrOut.intQueues <= xtrQueues & ~extMask;
			xtrOut.extValid  <= xtrReq && |(xtrQueues & extMask);
			xtrOut.intValid  <= xtrReq && |(xtrQueues & ~extMask);
			xtrOut.extPort   <= extPort;
			if (xtrReq && |(xtrQueues & extMask)) begin
				xtrCount <= xtrCount + 8'h01;
			end
		end
	end

	// egress: header insertion ahead of destination address
	ecf_tx_state_t      txState;
	logic [4:0]         txCnt;
	logic [HDR_BYTES*8-1:0] txHdr;
	ecf_byte_t          held;
	logic               egInFrame;
	logic               insStart;

	assign insStart = txState == TX_PASS && egReady && egIn.valid && !egInFrame && insEn[egIn.port];

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			egInFrame <= 1'b0;
		end else if (egReady && egIn.valid) begin
			egInFrame <= !egIn.last;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			txState <= TX_PASS;
			txCnt   <= 5'h00;
			txHdr   <= '0;
			held    <= '0;
			egReady <= 1'b1;
			txOut   <= '0;
		end else begin
			unique case (txState)
				TX_PASS: begin
					txOut <= egIn;
					txOut.valid <= egIn.valid && egReady;
					if (insStart) begin
						held        <= egIn;
						txHdr       <= {egHeader[HDR_BYTES*8-9:0], 8'h00};
						txOut.data  <= egHeader[HDR_BYTES*8-1 -: 8];
						txOut.last  <= 1'b0;
						txCnt       <= 5'h01;
						egReady     <= 1'b0;
						txState     <= TX_HDR;
					end
				end
				TX_HDR: begin
					txOut.valid <= 1'b1;
					txOut.data  <= txHdr[HDR_BYTES*8-1 -: 8];
					txOut.last  <= 1'b0;
					txHdr       <= {txHdr[HDR_BYTES*8-9:0], 8'h00};
					txCnt       <= txCnt + 5'h01;
					if (txCnt == 5'(HDR_BYTES - 1)) begin
						txState <= TX_HELD;
					end
				end
				TX_HELD: begin
					txOut   <= held;
					egReady <= 1'b1;
					txState <= TX_PASS;
				end
				default: begin
					txState <= TX_PASS;
					egReady <= 1'b1;
					txOut   <= '0;
				end
			endcase
		end
	end

	// ingress: injection header detection and parsing
	ecf_rx_state_t          rxState;
	logic [4:0]             rxCnt;
	logic [HDR_BYTES*8-1:0] injHdr;
	logic                   hdrShift;
	logic                   hdrDone;

	assign hdrShift = rxIn.valid && (rxState == RX_HDR || (rxState == RX_IDLE && detEn[rxIn.port]));
	assign hdrDone  = rxState == RX_HDR && rxIn.valid && !rxIn.last && rxCnt == 5'(HDR_BYTES - 1);

	ecf_hdr_shift #(
		.NBYTES (HDR_BYTES)
	) u_hdr (
		.core_clk (core_clk),
		.rst      (rst),
		.shiftEn  (hdrShift),
		.byteIn   (rxIn.data),
		.hdr      (injHdr)
	);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxState  <= RX_IDLE;
			rxCnt    <= 5'h00;
			coreOut  <= '0;
			coreMeta <= '0;
			injCount <= 8'h00;
		end else begin
			coreOut.valid  <= 1'b0;
			coreMeta.valid <= 1'b0;
			unique case (rxState)
				RX_IDLE: begin
					if (rxIn.valid && detEn[rxIn.port]) begin
						rxCnt   <= 5'h01;
						rxState <= rxIn.last ? RX_IDLE : RX_HDR;
					end else if (rxIn.valid) begin
						coreOut        <= rxIn;
						coreMeta       <= '{valid: 1'b1, bypass: 1'b0, destMask: '0, srcPort: rxIn.port};
						rxState        <= rxIn.last ? RX_IDLE : RX_BODY;
					end
				end
				RX_HDR: begin
					if (rxIn.valid) begin
						rxCnt <= rxCnt + 5'h01;
						if (rxIn.last) begin
							rxState <= RX_IDLE;
						end else if (hdrDone) begin
							coreMeta.valid    <= 1'b1;
							coreMeta.bypass   <= injHdr[INJ_BYPASS_BIT - 8];
							coreMeta.destMask <= injHdr[INJ_DEST_LSB - 8 +: NUM_PORTS];
							coreMeta.srcPort  <= CPU_PORT;
							injCount          <= injCount + 8'h01;
							rxState           <= RX_BODY;
						end
					end
				end
				RX_BODY: begin
					if (rxIn.valid) begin
						coreOut      <= rxIn;
						coreOut.port <= coreMeta.srcPort;
						if (rxIn.last) begin
							rxState <= RX_IDLE;
						end
					end
				end
				default: rxState <= RX_IDLE;
			endcase
		end
	end

	// checks
	sequence s_insStart;
		insStart;
	endsequence

	sequence s_hdrBurst;
		txOut.valid[*8] ##1 !egReady;
	endsequence

	a_ext_route: assert property (@(posedge core_clk) disable iff (rst)
		1'b1 |=> xtrOut.extQueues == ($past(xtrQueues) & $past(extMask))) else $error("external queue set wrong");
	a_int_route: assert property (@(posedge core_clk) disable iff (rst)
		1'b1 |=> xtrOut.intQueues == ($past(xtrQueues) & ~$past(extMask))) else $error("internal queue set wrong");
	a_dual_copy: assert property (@(posedge core_clk) disable iff (rst)
		xtrReq && |(xtrQueues & extMask) && |(xtrQueues & ~extMask) |=> xtrOut.extValid && xtrOut.intValid)
		else $error("dual copy missing");
	a_ext_port: assert property (@(posedge core_clk) disable iff (rst)
		xtrOut.extValid |-> xtrOut.extPort == $past(extPort)) else $error("external port wrong");
	a_hdr_length: assert property (@(posedge core_clk) disable iff (rst)
		s_insStart |-> ##20 (txState == TX_HELD)) else $error("header not twenty bytes");
	a_hdr_burst: assert property (@(posedge core_clk) disable iff (rst)
		s_insStart |=> s_hdrBurst) else $error("header bytes not back to back");
	a_inj_source: assert property (@(posedge core_clk) disable iff (rst)
		hdrDone |=> coreMeta.valid && coreMeta.srcPort == CPU_PORT) else $error("injected source port wrong");
	a_inj_count: assert property (@(posedge core_clk) disable iff (rst)
		hdrDone |=> rxState == RX_BODY && rxCnt == 5'(HDR_BYTES)) else $error("injection header length wrong");
	a_inj_decode: assert property (@(posedge core_clk) disable iff (rst)
		hdrDone |=> coreMeta.bypass == injHdr[INJ_BYPASS_BIT] && coreMeta.destMask == injHdr[INJ_DEST_LSB +: NUM_PORTS])
		else $error("forward mode wrong");
	a_plain_pass: assert property (@(posedge core_clk) disable iff (rst)
		rxState == RX_IDLE && rxIn.valid && !detEn[rxIn.port] |=> coreOut.valid && coreOut.data == $past(rxIn.data))
		else $error("plain frame not passed");
	a_bus_resp: assert property (@(posedge core_clk) disable iff (rst)
		wrFire |=> s_axi_bvalid ##0 (!s_axi_awready && !s_axi_wready)) else $error("write response missing");

endmodule : ecf_frame_port
`default_nettype wire

// *** rtl/ecf_pkg.sv ***
package ecf_pkg;

	// geometry
	localparam int          HDR_BYTES  = 20;
	localparam int          NUM_QUEUES = 8;
	localparam int          NUM_PORTS  = 12;
	localparam int          PORT_W     = 4;
	localparam logic [3:0]  CPU_PORT   = 4'hB;

	// register byte addresses
	localparam logic [3:0]  OFS_EXT_CFG   = 4'h0;
	localparam logic [3:0]  OFS_PORT_MODE = 4'h4;
	localparam logic [3:0]  OFS_STATUS    = 4'h8;

	// field positions
	localparam int          EXT_PORT_LSB  = 0;
	localparam int          EXT_MASK_LSB  = 8;
	localparam int          INS_EN_LSB    = 0;
	localparam int          DET_EN_LSB    = 16;

	// reset values
	localparam logic [3:0]  RST_EXT_PORT  = 4'h0;
	localparam logic [7:0]  RST_EXT_MASK  = 8'h00;
	localparam logic [11:0] RST_PORT_EN   = 12'h000;

	// injection header fields, bit positions in the 160-bit header
	localparam int          INJ_BYPASS_BIT = 152;
	localparam int          INJ_DEST_LSB   = 136;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {RX_IDLE = 2'h0, RX_HDR = 2'h1, RX_BODY = 2'h3} ecf_rx_state_t;
	typedef enum logic [1:0] {TX_PASS = 2'h0, TX_HDR = 2'h1, TX_HELD = 2'h3} ecf_tx_state_t;

	typedef struct packed {
		logic             valid;
		logic [7:0]       data;
		logic             last;
		logic [PORT_W-1:0] port;
	} ecf_byte_t;

	typedef struct packed {
		logic                  valid;
		logic                  bypass;
		logic [NUM_PORTS-1:0]  destMask;
		logic [PORT_W-1:0]     srcPort;
	} ecf_meta_t;

	typedef struct packed {
		logic                  extValid;
		logic                  intValid;
		logic [NUM_QUEUES-1:0] extQueues;
		logic [NUM_QUEUES-1:0] intQueues;
		logic [PORT_W-1:0]     extPort;
	} ecf_xtr_t;

endpackage : ecf_pkg

// *** rtl/ecf_hdr_shift.sv ***
`timescale 1ns/100ps
`default_nettype none
module ecf_hdr_shift #(
	parameter int NBYTES = 20
) (
	// clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// byte in
	input  wire logic                 shiftEn,
	input  wire logic [7:0]           byteIn,
	// collected header, first byte in the top lane
	output logic      [NBYTES*8-1:0]  hdr
);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hdr <= '0;
		end else if (shiftEn) begin
			hdr <= {hdr[NBYTES*8-9:0], byteIn};
		end
	end

endmodule : ecf_hdr_shift
`default_nettype wire

// *** test/ecf_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ecf_host_model import ecf_pkg::*; (
	// clock and reset
	input  wire logic      core_clk,
	input  wire logic      rst,
	// front port stream
	input  wire ecf_byte_t txOut,
	output ecf_byte_t      rxIn
);
	logic [7:0] rxBytes[$];
	logic [4:0] rxTags[$];

	// collect every byte that leaves the switch, whatever its port tag
	always @(posedge core_clk) begin
		if (!rst && txOut.valid === 1'b1) begin
			rxBytes.push_back(txOut.data);
			rxTags.push_back({txOut.last, txOut.port});
		end
	end

	initial rxIn = '0;

	// one frame: optional injection header, then body bytes A0+i
	task automatic send(input logic [3:0] port, input logic inj, input logic byp, input logic [11:0] dst,
			input int nb);
		logic [7:0] hb[HDR_BYTES];
		int         n;
		for (int i = 0; i < HDR_BYTES; i++) begin
			hb[i] = 8'h00;
		end
		hb[0] = {7'h00, byp};
		hb[1] = {4'h0, dst[11:8]};
		hb[2] = dst[7:0];
		n = inj ? HDR_BYTES + nb : nb;
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			// header leads, destination address follows it
			rxIn <= '{valid: 1'b1, data: (inj && i < HDR_BYTES) ? hb[i] : 8'hA0 + i[7:0], last: i == n - 1,
				port: port};
		end
		@(posedge core_clk);
		// released line shows inverted data, never the last value
		rxIn <= '{valid: 1'b0, data: ~rxIn.data, last: 1'b0, port: port};
	endtask : send
endmodule : ecf_host_model
`default_nettype wire

// *** test/external_cpu_frame_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module external_cpu_frame_port_tb import ecf_pkg::*;;
	logic                core_clk = 1'b0;
	logic                rst = 1'b1;
	logic [3:0]          s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '0;
	logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0]         s_axi_wdata = '0;
	logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]          s_axi_bresp, s_axi_rresp;
	logic [31:0]         s_axi_rdata;
	logic                xtrReq = 1'b0;
	logic [7:0]          xtrQueues = '0;
	ecf_xtr_t            xtrOut;
	ecf_byte_t           egIn = '0, txOut, rxIn, coreOut;
	logic [159:0]        egHeader = '0;
	logic                egReady;
	ecf_meta_t           coreMeta, lastMeta;
	logic [12:0]         bodyQ[$];
	logic [7:0]          expByte;
	int                  mismatches = 0, total_checks = 0, cycles = 0;

	always #12.5 core_clk = ~core_clk;

	ecf_frame_port u_ecf_frame_port (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .xtrReq(xtrReq), .xtrQueues(xtrQueues), .xtrOut(xtrOut), .egIn(egIn),
		.egHeader(egHeader), .egReady(egReady), .txOut(txOut), .rxIn(rxIn), .coreOut(coreOut),
		.coreMeta(coreMeta));

	ecf_host_model u_ecf_host_model (.core_clk(core_clk), .rst(rst), .txOut(txOut), .rxIn(rxIn));

	// record what the core receives
	always @(posedge core_clk) begin
		if (coreMeta.valid === 1'b1) begin
			lastMeta <= coreMeta;
		end
		if (coreOut.valid === 1'b1) begin
			bodyQ.push_back({coreOut.last, coreOut.port, coreOut.data});
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				s_axi_wvalid <= 1'b0;
			end
		end while (s_axi_bvalid !== 1'b1);
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
	endtask : axi_write

	task automatic axi_read(input string name, input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) begin
				s_axi_arvalid <= 1'b0;
			end
		end while (s_axi_rvalid !== 1'b1);
		check(name, s_axi_rdata, ed);
		check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask : axi_read

	task automatic eg_frame(input logic [3:0] port, input int nb);
		for (int i = 0; i < nb; i++) begin
			egIn <= '{valid: 1'b1, data: 8'h30 + i[7:0], last: i == nb - 1, port: port};
			do @(posedge core_clk); while (egReady !== 1'b1);
		end
		egIn.valid <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : eg_frame

	logic [7:0]  qs[3] = '{8'h33, 8'h0F, 8'hF0};
	logic [11:0] dsts[3] = '{12'hA5C, 12'h3F0, 12'h000};

	initial begin
		for (int k = 0; k < HDR_BYTES; k++) begin
			egHeader[159 - 8 * k -: 8] = 8'h80 + k[7:0];
		end
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		axi_read("cfg", OFS_EXT_CFG, 32'h0, RESP_OKAY);
		axi_read("mode", OFS_PORT_MODE, 32'h0, RESP_OKAY);
		axi_read("status", OFS_STATUS, 32'h0, RESP_OKAY);
		axi_write(4'hC, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
		axi_read("unmapped", 4'hC, 32'h0, RESP_SLVERR);
		axi_write(OFS_EXT_CFG, 32'h0000_0F03, 4'hF, RESP_OKAY);
		axi_write(OFS_PORT_MODE, 32'h0008_0008, 4'hF, RESP_OKAY);
		axi_write(OFS_STATUS, 32'h0000_FFFF, 4'hF, RESP_OKAY);
		axi_read("cfg", OFS_EXT_CFG, 32'h0000_0F03, RESP_OKAY);
		axi_read("mode", OFS_PORT_MODE, 32'h0008_0008, RESP_OKAY);
		// extraction split over the mask: both, external only, internal only
		for (int k = 0; k < 3; k++) begin
			xtrReq <= 1'b1;
			xtrQueues <= qs[k];
			@(posedge core_clk);
			xtrReq <= 1'b0;
			@(posedge core_clk);
			check("xtr", {10'h0, xtrOut}, {10'h0, |(qs[k] & 8'h0F), |(qs[k] & 8'hF0), qs[k] & 8'h0F,
				qs[k] & 8'hF0, 4'h3});
		end
		// header goes out first on the enabled port
		eg_frame(4'h3, 2);
		check("txlen", u_ecf_host_model.rxBytes.size(), HDR_BYTES + 2);
		for (int k = 0; k < HDR_BYTES + 2; k++) begin
			expByte = (k < HDR_BYTES) ? 8'h80 + k[7:0] : 8'h30 + k[7:0] - 8'(HDR_BYTES);
			check("txbyte", {24'h0, u_ecf_host_model.rxBytes[k]}, {24'h0, expByte});
			check("txtag", {27'h0, u_ecf_host_model.rxTags[k]}, {27'h0, k == HDR_BYTES + 1, 4'h3});
		end
		u_ecf_host_model.rxBytes.delete();
		u_ecf_host_model.rxTags.delete();
		eg_frame(4'h2, 2);
		check("plainlen", u_ecf_host_model.rxBytes.size(), 2);
		check("plain0", {24'h0, u_ecf_host_model.rxBytes[0]}, 32'h30);
		check("plaintag", {27'h0, u_ecf_host_model.rxTags[0]}, {27'h0, 1'b0, 4'h2});
		// injected bypass, injected analyzer, plain on a port without detection
		for (int k = 0; k < 3; k++) begin
			bodyQ.delete();
			u_ecf_host_model.send(k < 2 ? 4'h3 : 4'h2, k < 2, k == 0, dsts[k], 2);
			repeat (4) @(posedge core_clk);
			check("srcport", {28'h0, lastMeta.srcPort}, k < 2 ? 32'hB : 32'h2);
			check("bypass", {31'h0, lastMeta.bypass}, {31'h0, k == 0});
			if (k < 2) begin
				check("dest", {20'h0, lastMeta.destMask}, {20'h0, dsts[k]});
			end
			check("bodylen", bodyQ.size(), 2);
			check("body0", {19'h0, bodyQ[0]}, k < 2 ? {20'h0, 4'hB, 8'hB4} : {20'h0, 4'h2, 8'hA0});
			check("body1", {19'h0, bodyQ[1]}, k < 2 ? {20'h1, 4'hB, 8'hB5} : {20'h1, 4'h2, 8'hA1});
		end
		// byte strobes: only the mask lane is written
		axi_write(OFS_EXT_CFG, 32'hFFFF_F0FF, 4'h2, RESP_OKAY);
		axi_read("cfgmask", OFS_EXT_CFG, 32'h0000_F003, RESP_OKAY);
		xtrReq <= 1'b1;
		xtrQueues <= 8'h33;
		@(posedge core_clk);
		xtrReq <= 1'b0;
		@(posedge core_clk);
		check("xtrmask", {10'h0, xtrOut}, {10'h0, 1'b1, 1'b1, 8'h30, 8'h03, 4'h3});
		axi_read("status", OFS_STATUS, 32'h0000_0302, RESP_OKAY);
		tally_and_finish();
	end
endmodule : external_cpu_frame_port_tb
`default_nettype wire
